// File: design/ddc_regs.sv
// datapath configuration register bank with its serial control slave
`timescale 1ns/100ps
module ddc_regs (
  input wire logic clk, // 250 MHz system clock
  input wire logic rst, // async reset, active high
  input wire logic serial_clock, // host serial clock pin
  input wire logic serial_enable_n, // host frame enable pin, active low
  input wire logic serial_data_in, // two-way data pin, input side
  output logic serial_data_out, // two-way data pin, output side
  output logic serial_data_oe, // two-way data pin, high while driving
  input wire logic sync_marker, // frame marker pin
  input wire logic output_sync_strobe, // output sync strobe pin
  input wire logic multi_sync_sel, // read pointer source: 1 strobe, 0 marker
  input wire logic [6:0] alarm_status, // recorded alarms from the status bank
  input wire logic [6:0] alarm_mask, // 1 keeps that alarm off the pin
  input wire logic ptr_gap_two, // fifo pointers within two positions
  input wire logic ptr_gap_one, // fifo pointers within one position
  input wire logic good_sample, // one-cycle pulse per good input sample
  input wire logic bad_sample, // one-cycle pulse per bad input sample
  output ddc_pkg::ddc_cfg_t cfg, // configuration to the datapath
  output logic write_ptr_reset, // pulse: reset fifo write pointer
  output logic read_ptr_reset, // pulse: load read pointer with offset
  output logic near_two_alarm, // fifo alarm, pointers within two
  output logic near_one_alarm, // fifo alarm, pointers within one
  output logic alarm_auto_clear, // pulse: clear latched alarms
  output logic alarm_serial_out_pin, // alarm pin level
  output logic alarm_serial_out_oe // alarm pin enable
);
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic sclk_prev;
  logic marker_prev;
  logic strobe_prev;
  logic [7:0] cfg_reg [ddc_pkg::DDC_NUM_REGS];
  logic [7:0] next_cfg_reg [ddc_pkg::DDC_NUM_REGS];
  ddc_pkg::ddc_ser_state_t state;
  ddc_pkg::ddc_ser_state_t next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic is_read;
  logic next_is_read;
  logic [4:0] addr;
  logic [4:0] next_addr;
  logic next_sdo;
  logic next_sdo_oe;
  logic [5:0] good_cnt;
  logic [5:0] next_good_cnt;
  logic next_auto_clear;
  logic next_wr_rst;
  logic next_rd_rst;
  logic next_alarm_pin;
  logic next_alarm_oe;
  logic sclk_s;
  logic sen_n_s;
  logic sdi_s;
  logic marker_s;
  logic strobe_s;
  logic sclk_rise;
  logic sclk_fall;
  logic marker_rise;
  logic strobe_rise;
  logic masked_any;
  logic sinc_gate;
  logic next_sinc_gate;
  logic next_near_two;
  logic next_near_one;

  function automatic logic [7:0] reg_read(input logic [4:0] a, input logic [7:0] r0,
                                          input logic [7:0] r1, input logic [7:0] r2,
                                          input logic [7:0] r3);
    logic [7:0] v;
    v = ddc_pkg::DDC_READ_UNMAPPED;
    case (a)
      ddc_pkg::DDC_ADDR_DATAPATH: v = r0;
      ddc_pkg::DDC_ADDR_FORMAT: v = r1;
      ddc_pkg::DDC_ADDR_LATENCY: v = r2;
      ddc_pkg::DDC_ADDR_QUEUE: v = r3;
      default: v = ddc_pkg::DDC_READ_UNMAPPED;
    endcase
    return v;
  endfunction

  // pins are asynchronous to clk; only the second stage is looked at
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= 5'h1E;
      sync2 <= 5'h1E;
      sclk_prev <= 1'b1;
      marker_prev <= 1'b0;
      strobe_prev <= 1'b0;
    end else begin
      sync1 <= {serial_enable_n, serial_clock, serial_data_in, sync_marker, output_sync_strobe};
      sync2 <= sync1;
      sclk_prev <= sclk_s;
      marker_prev <= marker_s;
      strobe_prev <= strobe_s;
    end
  end

  assign sen_n_s = sync2[4];
  assign sclk_s = sync2[3];
  assign sdi_s = sync2[2];
  assign marker_s = sync2[1];
  assign strobe_s = sync2[0];
  assign sclk_rise = sclk_s & ~sclk_prev;
  assign sclk_fall = ~sclk_s & sclk_prev;
  assign marker_rise = marker_s & ~marker_prev;
  assign strobe_rise = strobe_s & ~strobe_prev;

  // serial slave: instruction byte (read bit, address), then data bytes with address increment
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_is_read = is_read;
    next_addr = addr;
    next_sdo = serial_data_out;
    next_sdo_oe = serial_data_oe;
    for (int i = 0; i < ddc_pkg::DDC_NUM_REGS; i++) begin
      next_cfg_reg[i] = cfg_reg[i];
    end
    if (sen_n_s) begin
      next_state = ddc_pkg::DDC_SER_IDLE;
      next_sdo_oe = 1'b0;
      next_bit_cnt = 3'h0;
    end else begin
      unique case (state)
        ddc_pkg::DDC_SER_IDLE: begin
          next_state = ddc_pkg::DDC_SER_INSTR;
          next_bit_cnt = 3'h0;
        end
        ddc_pkg::DDC_SER_INSTR: begin
          if (sclk_rise) begin
            next_shift = {shift[6:0], sdi_s};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == ddc_pkg::DDC_BIT_LAST) begin
              next_is_read = shift[ddc_pkg::DDC_INSTR_RW - 1];
              next_addr = {shift[3:0], sdi_s};
              next_state = ddc_pkg::DDC_SER_DATA;
            end
          end
        end
        ddc_pkg::DDC_SER_DATA: begin
          if (is_read) begin
            // drive each bit on the falling edge so the host samples it on the rise
            if (sclk_fall) begin
              if (bit_cnt == 3'h0) begin
                next_shift = reg_read(addr, cfg_reg[0], cfg_reg[1], cfg_reg[2], cfg_reg[3]);
                next_sdo = next_shift[7];
              end else begin
                next_sdo = shift[3'h7 - bit_cnt];
              end
              next_sdo_oe = 1'b1;
            end
            if (sclk_rise) begin
              next_bit_cnt = bit_cnt + 3'h1;
              if (bit_cnt == ddc_pkg::DDC_BIT_LAST) begin
                next_addr = addr + 5'h01;
              end
            end
          end else if (sclk_rise) begin
            next_shift = {shift[6:0], sdi_s};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == ddc_pkg::DDC_BIT_LAST) begin
              next_state = ddc_pkg::DDC_SER_DONE;
            end
          end
        end
        ddc_pkg::DDC_SER_DONE: begin
          // commit only a whole byte; all bits kept as written, unused included
          if (addr < 5'(ddc_pkg::DDC_NUM_REGS)) begin
            next_cfg_reg[addr[1:0]] = shift;
          end
          next_addr = addr + 5'h01;
          next_state = ddc_pkg::DDC_SER_DATA;
        end
      endcase
    end
    // kept in a flop so the gated enable leaves the block registered
    next_sinc_gate = next_cfg_reg[1][ddc_pkg::DDC_FF_SINC_EN] &
                     next_cfg_reg[1][ddc_pkg::DDC_FF_INTERP_EN];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ddc_pkg::DDC_SER_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      is_read <= 1'b0;
      addr <= 5'h00;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
      cfg_reg[0] <= ddc_pkg::DDC_RST_DATAPATH;
      cfg_reg[1] <= ddc_pkg::DDC_RST_FORMAT;
      cfg_reg[2] <= ddc_pkg::DDC_RST_LATENCY;
      cfg_reg[3] <= ddc_pkg::DDC_RST_QUEUE;
      sinc_gate <= ddc_pkg::DDC_RST_FORMAT[ddc_pkg::DDC_FF_SINC_EN] &
                   ddc_pkg::DDC_RST_FORMAT[ddc_pkg::DDC_FF_INTERP_EN];
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      is_read <= next_is_read;
      addr <= next_addr;
      serial_data_out <= next_sdo;
      serial_data_oe <= next_sdo_oe;
      for (int i = 0; i < ddc_pkg::DDC_NUM_REGS; i++) begin
        cfg_reg[i] <= next_cfg_reg[i];
      end
      sinc_gate <= next_sinc_gate;
    end
  end

  // fields straight off the register flip-flops
  assign cfg.offset_correct_enable = cfg_reg[0][ddc_pkg::DDC_DP_OFFSET_EN];
  assign cfg.fifo_enable = cfg_reg[0][ddc_pkg::DDC_DP_FIFO_EN];
  assign cfg.mixer_mode =
    ddc_pkg::ddc_mixer_t'(cfg_reg[0][ddc_pkg::DDC_DP_MIXER_LSB +: 2]);
  assign cfg.interp_enable = cfg_reg[1][ddc_pkg::DDC_FF_INTERP_EN];
  // sinc filter is meaningless without interpolation, so it is gated off here
  assign cfg.sinc_correct_enable = sinc_gate;
  assign cfg.checker_enable = cfg_reg[1][ddc_pkg::DDC_FF_CHECKER_EN];
  assign cfg.twos_complement = cfg_reg[1][ddc_pkg::DDC_FF_TWOS];
  assign cfg.output_latency = cfg_reg[2][ddc_pkg::DDC_LAT_LSB +: 4];
  assign cfg.read_ptr_offset = cfg_reg[3][ddc_pkg::DDC_QA_RD_OFFSET_LSB +: 3];
  assign cfg.good_run_alarm_clear = cfg_reg[3][ddc_pkg::DDC_QA_GOOD_RUN_CLR];

  assign masked_any = |(alarm_status & ~alarm_mask);

  // pointer resets, proximity alarms, alarm pin and good-run clearing
  always_comb begin
    next_wr_rst = marker_rise & cfg_reg[0][ddc_pkg::DDC_DP_WRPTR_RST_EN];
    next_rd_rst = cfg_reg[0][ddc_pkg::DDC_DP_MULTI_SYNC_EN] &
                  (multi_sync_sel ? strobe_rise : marker_rise);
    next_near_two = ptr_gap_two & cfg_reg[3][ddc_pkg::DDC_QA_NEAR_TWO_EN];
    next_near_one = ptr_gap_one & cfg_reg[3][ddc_pkg::DDC_QA_NEAR_ONE_EN];
    next_alarm_oe = cfg_reg[0][ddc_pkg::DDC_DP_ALARM_OUT_EN];
    next_alarm_pin = cfg_reg[0][ddc_pkg::DDC_DP_ALARM_POL] ? masked_any : ~masked_any;
    next_good_cnt = good_cnt;
    next_auto_clear = 1'b0;
    // a bad sample restarts the run; only consecutive good ones count
    if (!cfg_reg[3][ddc_pkg::DDC_QA_GOOD_RUN_CLR] || bad_sample) begin
      next_good_cnt = 6'h00;
    end else if (good_sample) begin
      next_good_cnt = good_cnt + 6'h01;
      if (good_cnt == ddc_pkg::DDC_GOOD_RUN_LAST) begin
        next_auto_clear = 1'b1;
        next_good_cnt = 6'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_ptr_reset <= 1'b0;
      read_ptr_reset <= 1'b0;
      near_two_alarm <= 1'b0;
      near_one_alarm <= 1'b0;
      alarm_serial_out_pin <= 1'b1;
      alarm_serial_out_oe <= 1'b0;
      good_cnt <= 6'h00;
      alarm_auto_clear <= 1'b0;
    end else begin
      write_ptr_reset <= next_wr_rst;
      read_ptr_reset <= next_rd_rst;
      near_two_alarm <= next_near_two;
      near_one_alarm <= next_near_one;
      alarm_serial_out_pin <= next_alarm_pin;
      alarm_serial_out_oe <= next_alarm_oe;
      good_cnt <= next_good_cnt;
      alarm_auto_clear <= next_auto_clear;
    end
  end

  a_wr_ptr_gate: assert property (@(posedge clk) disable iff (rst)
    write_ptr_reset |-> $past(cfg_reg[0][ddc_pkg::DDC_DP_WRPTR_RST_EN]) && $past(marker_rise))
    else $error("write pointer reset without marker or enable");
  a_rd_ptr_src: assert property (@(posedge clk) disable iff (rst)
    read_ptr_reset |-> $past(cfg_reg[0][ddc_pkg::DDC_DP_MULTI_SYNC_EN]) &&
      ($past(multi_sync_sel) ? $past(strobe_rise) : $past(marker_rise)))
    else $error("read pointer reset from wrong source");
  a_alarm_pin_en: assert property (@(posedge clk) disable iff (rst)
    ##1 alarm_serial_out_oe == $past(cfg_reg[0][ddc_pkg::DDC_DP_ALARM_OUT_EN]))
    else $error("alarm pin enable not following its bit");
  a_alarm_polarity: assert property (@(posedge clk) disable iff (rst)
    // the release edge still holds the pin at its reset level, so no attempt starts there
    !rst |=> alarm_serial_out_pin ==
      ($past(masked_any) == $past(cfg_reg[0][ddc_pkg::DDC_DP_ALARM_POL])))
    else $error("alarm pin level wrong for polarity");
  a_mask_hides: assert property (@(posedge clk) disable iff (rst)
    ((alarm_status & ~alarm_mask) == 7'h00) |=> alarm_serial_out_pin ==
      ~cfg_reg[0][ddc_pkg::DDC_DP_ALARM_POL] || $changed(cfg_reg[0]))
    else $error("masked alarm reached the pin");
  a_sinc_needs_fir: assert property (@(posedge clk) disable iff (rst)
    cfg.sinc_correct_enable |-> cfg.interp_enable)
    else $error("sinc filter on without interpolation");
  a_near_two: assert property (@(posedge clk) disable iff (rst)
    near_two_alarm |-> $past(ptr_gap_two) && $past(cfg_reg[3][ddc_pkg::DDC_QA_NEAR_TWO_EN]))
    else $error("near-two alarm without cause");
  a_near_one: assert property (@(posedge clk) disable iff (rst)
    $past(ptr_gap_one) && $past(cfg_reg[3][ddc_pkg::DDC_QA_NEAR_ONE_EN]) |-> near_one_alarm)
    else $error("near-one alarm missed");
  a_good_run_clear: assert property (@(posedge clk) disable iff (rst)
    alarm_auto_clear |-> $past(good_cnt) == ddc_pkg::DDC_GOOD_RUN_LAST && $past(good_sample))
    else $error("alarm clear before 64 good samples");
  a_write_commit: assert property (@(posedge clk) disable iff (rst)
    $changed(cfg_reg[1]) |-> $past(state) == ddc_pkg::DDC_SER_DONE)
    else $error("register changed outside a completed write");
  a_read_drive: assert property (@(posedge clk) disable iff (rst)
    serial_data_oe |-> !$past(sen_n_s))
    else $error("data pin driven outside a frame");
  a_bad_restart: assert property (@(posedge clk) disable iff (rst)
    bad_sample |=> good_cnt == 6'h00 && !alarm_auto_clear)
    else $error("bad sample did not restart the good run");

  c_write_done: cover property (@(posedge clk) disable iff (rst)
    state == ddc_pkg::DDC_SER_DONE);
  c_read_byte: cover property (@(posedge clk) disable iff (rst)
    serial_data_oe && is_read);
  c_auto_clear: cover property (@(posedge clk) disable iff (rst) alarm_auto_clear);
  c_unmapped_write: cover property (@(posedge clk) disable iff (rst)
    state == ddc_pkg::DDC_SER_DONE && addr >= 5'(ddc_pkg::DDC_NUM_REGS));
  c_rd_ptr_strobe: cover property (@(posedge clk) disable iff (rst)
    read_ptr_reset && multi_sync_sel);
endmodule // ddc_regs

// File: inc/ddc_pkg.sv
// constants and types for the datapath configuration register bank
package ddc_pkg;
  // register offsets on the serial control interface
  localparam logic [4:0] DDC_ADDR_DATAPATH = 5'h00;
  localparam logic [4:0] DDC_ADDR_FORMAT = 5'h01;
  localparam logic [4:0] DDC_ADDR_LATENCY = 5'h02;
  localparam logic [4:0] DDC_ADDR_QUEUE = 5'h03;
  localparam int DDC_NUM_REGS = 4;
  // values after reset, and the value read back from unmapped addresses
  localparam logic [7:0] DDC_RST_DATAPATH = 8'h70;
  localparam logic [7:0] DDC_RST_FORMAT = 8'h11;
  localparam logic [7:0] DDC_RST_LATENCY = 8'h00;
  localparam logic [7:0] DDC_RST_QUEUE = 8'h10;
  localparam logic [7:0] DDC_READ_UNMAPPED = 8'h00;
  // datapath_control fields
  localparam int DDC_DP_OFFSET_EN = 7;
  localparam int DDC_DP_FIFO_EN = 6;
  localparam int DDC_DP_WRPTR_RST_EN = 5;
  localparam int DDC_DP_MULTI_SYNC_EN = 4;
  localparam int DDC_DP_ALARM_OUT_EN = 3;
  localparam int DDC_DP_ALARM_POL = 2;
  localparam int DDC_DP_MIXER_LSB = 0;
  // format_filter_control fields
  localparam int DDC_FF_INTERP_EN = 4;
  localparam int DDC_FF_SINC_EN = 3;
  localparam int DDC_FF_CHECKER_EN = 2;
  localparam int DDC_FF_TWOS = 0;
  // output_latency_control and queue_alarm_control fields
  localparam int DDC_LAT_LSB = 0;
  localparam int DDC_QA_GOOD_RUN_CLR = 7;
  localparam int DDC_QA_RD_OFFSET_LSB = 2;
  localparam int DDC_QA_NEAR_TWO_EN = 1;
  localparam int DDC_QA_NEAR_ONE_EN = 0;
  // serial framing, good-run length and alarm count
  localparam int DDC_INSTR_RW = 7;
  localparam logic [2:0] DDC_BIT_LAST = 3'h7;
  localparam logic [5:0] DDC_GOOD_RUN_LAST = 6'h3F; // 64 good samples
  localparam int DDC_ALARM_BITS = 7;

  typedef enum logic [1:0] {
    DDC_MIX_PASS = 2'b00,
    DDC_MIX_HALF = 2'b01,
    DDC_MIX_QUARTER_POS = 2'b10,
    DDC_MIX_QUARTER_NEG = 2'b11
  } ddc_mixer_t;

  typedef enum logic [1:0] {
    DDC_SER_IDLE = 2'b00,
    DDC_SER_INSTR = 2'b01,
    DDC_SER_DATA = 2'b10,
    DDC_SER_DONE = 2'b11
  } ddc_ser_state_t;

  typedef struct packed {
    logic offset_correct_enable;
    logic fifo_enable;
    logic interp_enable;
    logic sinc_correct_enable;
    logic checker_enable;
    logic twos_complement;
    ddc_mixer_t mixer_mode;
    logic [3:0] output_latency;
    logic [2:0] read_ptr_offset;
    logic good_run_alarm_clear;
  } ddc_cfg_t;
endpackage

// File: verification/ddc_host_model.sv
// serial control host model driving the configuration register bank
`timescale 1ns/100ps
module ddc_host_model (
  input wire logic clk, // system clock, paces the serial phases
  input wire logic sdio, // resolved level of the data pin
  output logic serial_clock, // serial clock, idle high
  output logic serial_enable_n, // frame enable, active low
  output logic host_data, // level the host puts on the data pin
  output logic host_oe, // high while the host drives the data pin
  output logic rd_done, // one-cycle pulse when a read byte is complete
  output logic [7:0] rd_byte // byte captured by the last read
);
  // clk per serial phase; the bench varies it for slow frames, never below 6
  int half = 6;
  initial begin
    serial_clock = 1'b1;
    serial_enable_n = 1'b1;
    host_data = 1'b0;
    host_oe = 1'b0;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end
  // one frame: instruction byte, then one data byte, msb first
  task automatic xfer(input logic rd, input logic [4:0] addr, input logic [7:0] wdata);
    logic [15:0] bits;
    bits = {rd, 2'b00, addr, wdata};
    @(posedge clk);
    serial_enable_n <= 1'b0;
    // the slave may still hold the pin from a read; take it only with the first bit
    for (int i = 15; i >= 0; i--) begin
      repeat (half) @(posedge clk);
      serial_clock <= 1'b0;
      if (rd && i < 8) begin
        host_oe <= 1'b0;
      end else begin
        host_oe <= 1'b1;
        host_data <= bits[i];
      end
      repeat (half) @(posedge clk);
      if (rd && i < 8) begin
        rd_byte[i] <= sdio;
      end
      serial_clock <= 1'b1;
    end
    repeat (half) @(posedge clk);
    serial_enable_n <= 1'b1;
    host_oe <= 1'b0;
    rd_done <= rd;
    @(posedge clk);
    rd_done <= 1'b0;
  endtask
endmodule // ddc_host_model

// File: verification/ddc_regs_bench.sv
// self-checking bench for the datapath configuration register bank
`timescale 1ns/100ps
module ddc_regs_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sync_marker = 1'b0;
  logic output_sync_strobe = 1'b0;
  logic multi_sync_sel = 1'b0;
  logic [6:0] alarm_status = 7'h00;
  logic [6:0] alarm_mask = 7'h00;
  logic ptr_gap_two = 1'b0;
  logic ptr_gap_one = 1'b0;
  logic good_sample = 1'b0;
  logic bad_sample = 1'b0;
  logic sdio_last = 1'b0;
  logic sclk, sen_n, host_data, host_oe, rd_done, sdo, sdo_oe;
  logic wr_rst, rd_rst, near_two, near_one, auto_clr, apin, apin_oe;
  logic [7:0] rd_byte;
  logic [6:0] st;
  logic act;
  wire sdio;
  ddc_pkg::ddc_cfg_t cfg;
  logic [7:0] shadow [4];
  logic [7:0] exp_q [$];
  int fail_count = 0;
  int checked = 0;
  int seed;
  // bits that carry a field; the rest stay zero in normal traffic
  localparam logic [7:0] USED [4] = '{8'hFF, 8'h1D, 8'h0F, 8'h9F};

  always #2 clk = ~clk;
  // a released data pin shows the inverse of its last level, not a stale copy
  assign sdio = sdo_oe ? sdo : (host_oe ? host_data : ~sdio_last);
  always @(posedge clk) sdio_last <= sdio;

  ddc_regs u_ddc_regs (.clk(clk), .rst(rst), .serial_clock(sclk), .serial_enable_n(sen_n),
    .serial_data_in(sdio), .serial_data_out(sdo), .serial_data_oe(sdo_oe),
    .sync_marker(sync_marker), .output_sync_strobe(output_sync_strobe),
    .multi_sync_sel(multi_sync_sel), .alarm_status(alarm_status), .alarm_mask(alarm_mask),
    .ptr_gap_two(ptr_gap_two), .ptr_gap_one(ptr_gap_one), .good_sample(good_sample),
    .bad_sample(bad_sample), .cfg(cfg), .write_ptr_reset(wr_rst), .read_ptr_reset(rd_rst),
    .near_two_alarm(near_two), .near_one_alarm(near_one), .alarm_auto_clear(auto_clr),
    .alarm_serial_out_pin(apin), .alarm_serial_out_oe(apin_oe));
  ddc_host_model u_ddc_host_model (.clk(clk), .sdio(sdio), .serial_clock(sclk),
    .serial_enable_n(sen_n), .host_data(host_data), .host_oe(host_oe), .rd_done(rd_done),
    .rd_byte(rd_byte));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic ddc_pkg::ddc_cfg_t exp_cfg();
    ddc_pkg::ddc_cfg_t c;
    c.offset_correct_enable = shadow[0][7];
    c.fifo_enable = shadow[0][6];
    c.interp_enable = shadow[1][4];
    c.sinc_correct_enable = shadow[1][3] & shadow[1][4];
    c.checker_enable = shadow[1][2];
    c.twos_complement = shadow[1][0];
    c.mixer_mode = ddc_pkg::ddc_mixer_t'(shadow[0][1:0]);
    c.output_latency = shadow[2][3:0];
    c.read_ptr_offset = shadow[3][4:2];
    c.good_run_alarm_clear = shadow[3][7];
    return c;
  endfunction

  task automatic reg_wr(input logic [4:0] addr, input logic [7:0] data);
    u_ddc_host_model.xfer(1'b0, addr, data);
    if (addr < 5'h04) shadow[addr[1:0]] = data;
  endtask

  task automatic reg_rd(input logic [4:0] addr);
    exp_q.push_back(addr < 5'h04 ? shadow[addr[1:0]] : 8'h00);
    u_ddc_host_model.xfer(1'b1, addr, 8'h00);
  endtask

  task automatic sync_try(input logic strobe, input int exp_wr, input int exp_rd);
    int nw;
    int nr;
    nw = 0;
    nr = 0;
    @(posedge clk);
    sync_marker <= !strobe;
    output_sync_strobe <= strobe;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      nw += int'(wr_rst === 1'b1);
      nr += int'(rd_rst === 1'b1);
    end
    sync_marker <= 1'b0;
    output_sync_strobe <= 1'b0;
    check("write ptr resets", exp_wr, nw);
    check("read ptr resets", exp_rd, nr);
  endtask

  task automatic run_good(input int n, input int bad_at, input int exp_n);
    int seen;
    seen = 0;
    for (int i = 0; i < n + 4; i++) begin
      @(posedge clk);
      good_sample <= (i < n) && (i != bad_at);
      bad_sample <= (i == bad_at);
      seen += int'(auto_clr === 1'b1);
    end
    check("auto clear count", exp_n, seen);
  endtask

  // read results are compared in arrival order against the noted values
  always @(posedge clk) begin
    if (rd_done === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected read", 32'h0, 32'h1);
      else check("read data", exp_q.pop_front(), rd_byte);
    end
  end

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    $display("Error watchdog expected finish seen hang");
    print_verdict();
  end

  initial begin
    seed = $urandom(56);
    shadow = '{8'h70, 8'h11, 8'h00, 8'h10};
    repeat (8) @(posedge clk);
    check("reset cfg", exp_cfg(), cfg);
    check("reset alarm oe", 1'b0, apin_oe);
    check("reset alarm pin", 1'b1, apin);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 4; a++) reg_rd(5'(a));
    for (int m = 0; m < 4; m++) begin
      reg_wr(5'h00, 8'h70 | 8'(m));
      check("mixer cfg", exp_cfg(), cfg);
    end
    for (int k = 0; k < 6; k++) begin
      u_ddc_host_model.half = 6 + int'($urandom % 7);
      for (int a = 0; a < 4; a++) reg_wr(5'(a), 8'($urandom) & USED[a]);
      check("random cfg", exp_cfg(), cfg);
      for (int a = 0; a < 4; a++) reg_rd(5'(a));
    end
    for (int a = 1; a < 4; a++) begin
      reg_wr(5'(a), ~USED[a]);
      reg_rd(5'(a));
      reg_wr(5'(a), 8'h00);
    end
    reg_wr(5'h01, 8'h08);
    check("sinc without interp", exp_cfg(), cfg);
    reg_wr(5'h01, 8'h18);
    check("sinc with interp", exp_cfg(), cfg);
    reg_wr(5'h04, 8'hA5);
    reg_wr(5'h1F, 8'h5A);
    reg_rd(5'h04);
    for (int a = 0; a < 4; a++) reg_rd(5'(a));
    for (int d = 0; d < 2; d++) begin
      reg_wr(5'h00, d ? 8'h00 : 8'h30);
      for (int s = 0; s < 4; s++) begin
        multi_sync_sel <= s[1];
        sync_try(s[0], int'(shadow[0][5] & !s[0]), int'(shadow[0][4] & (s[1] == s[0])));
      end
    end
    for (int e = 0; e < 4; e++) begin
      reg_wr(5'h03, 8'h10 | 8'(e));
      for (int g = 0; g < 4; g++) begin
        @(posedge clk);
        ptr_gap_two <= g[1];
        ptr_gap_one <= g[0];
        repeat (3) @(posedge clk);
        check("near two alarm", e[1] & g[1], near_two);
        check("near one alarm", e[0] & g[0], near_one);
      end
    end
    for (int i = 0; i < 4; i++) begin
      reg_wr(5'h00, 8'h70 | 8'(i << 2));
      for (int j = 0; j < 4; j++) begin
        st = 7'($urandom);
        @(posedge clk);
        alarm_status <= st;
        alarm_mask <= (j == 0) ? ~st : 7'($urandom);
        repeat (3) @(posedge clk);
        act = |(alarm_status & ~alarm_mask);
        check("alarm oe", shadow[0][3], apin_oe);
        if (shadow[0][3]) check("alarm pin", shadow[0][2] ? act : !act, apin);
      end
    end
    reg_wr(5'h03, 8'h90);
    run_good(64, -1, 1);
    run_good(104, 40, 0);
    reg_wr(5'h03, 8'h10);
    run_good(64, -1, 0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    shadow = '{8'h70, 8'h11, 8'h00, 8'h10};
    repeat (4) @(posedge clk);
    check("cfg after reset", exp_cfg(), cfg);
    reg_rd(5'h00);
    repeat (4) @(posedge clk);
    check("reads pending", 0, exp_q.size());
    print_verdict();
  end
endmodule // ddc_regs_bench
